// ---- design/flash_pkg.sv ----
package flash_pkg;

    // array geometry
    localparam int PAGE_BYTES   = 256;
    localparam int SECTOR_PAGES = 256;
    localparam int SECTORS      = 16;
    localparam int MEM_BYTES    = PAGE_BYTES * SECTOR_PAGES * SECTORS;

    // lowest 256 pages end here; write protect guards everything below
    localparam logic [19:0] PROT_LIMIT  = 20'h10000;
    // last offset walked by a page or a sector sweep
    localparam logic [15:0] PAGE_LAST   = 16'h00FF;
    localparam logic [15:0] SECTOR_LAST = 16'hFFFF;
    // byte counter ceiling and size of opcode plus address
    localparam logic [9:0]  BYTES_MAX   = 10'h3FF;
    localparam logic [9:0]  HDR_BYTES   = 10'h004;
    localparam logic [9:0]  DATA_FIRST  = 10'h005;
    // value of an erased byte
    localparam logic [7:0]  ERASED      = 8'hFF;

    // instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PW   = 8'h0A;
    localparam logic [7:0] OP_PP   = 8'h02;
    localparam logic [7:0] OP_PE   = 8'hDB;
    localparam logic [7:0] OP_SE   = 8'hD8;

    // status byte bit positions
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;

    // internal cycle sequencer
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_FILL, SEQ_ERASE, SEQ_PROG} seq_e;

    // summary of the last frame, stable while select is high
    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic        bits_ok;
        logic        has_data;
    } cmd_s;

    // pins sampled into the system clock
    typedef struct packed {
        logic cs_n;
        logic reset_n;
        logic wp_n;
    } pins_s;

    // system state handed to the serial clock
    typedef struct packed {
        logic wip;
        logic wel;
        logic armed;
    } stat_s;

endpackage : flash_pkg

// ---- design/flash_sync2.sv ----
// two-flop level synchroniser; first stage feeds only the second
module flash_sync2 #(
    parameter int W = 1
) (
    // destination clock
    input  wire logic         clk,
    // asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;   // first stage, metastable window

    // plain shift, no reset needed on a pure synchroniser
    always_ff @(posedge clk) begin
        meta_reg <= d;
        q        <= meta_reg;
    end

endmodule : flash_sync2

// ---- design/flash_link.sv ----
// serial front end, clocked by the bus clock
module flash_link (
    // serial pins
    input  wire logic              sck,
    input  wire logic              cs_n,
    input  wire logic              din,
    // reset mode from the system side
    input  wire logic              rst_mode,
    // system status, already synchronised to sck
    input  wire flash_pkg::stat_s  stat,
    // array read port
    input  wire logic [7:0]        rd_data,
    output logic      [19:0]       rd_addr,
    // page buffer read port
    input  wire logic [7:0]        buf_idx,
    output logic      [7:0]        buf_data,
    // frame summary
    output flash_pkg::cmd_s        cmd,
    output logic      [255:0]      mask,
    // serial output pin
    output logic                   dout,
    output logic                   dout_oe
);

    logic          fresh_reg;                 // no rising edge yet in this frame
    logic [2:0]    bits_reg, bits_next;       // bit within byte
    logic [9:0]    bytes_reg, bytes_next;     // whole bytes seen, saturating
    logic [6:0]    shift_reg, shift_next;     // incoming bits
    logic [7:0]    op_reg, op_next;
    logic [23:0]   addr_reg, addr_next;
    logic [255:0]  mask_reg, mask_next;       // page buffer bytes loaded
    logic [7:0]    pbuf [0:255];              // page buffer
    logic          buf_we;
    logic [7:0]    byte_in;
    logic [7:0]    out_reg, out_next;
    logic          dout_next, oe_next, out_phase, clr;
    logic [7:0]    src;

    localparam logic [9:0] HDR_BYTES_L = flash_pkg::HDR_BYTES;   // opcode plus address bytes

    // select high marks the next frame as fresh; counts restart there
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // input side: sample on rising edge, msb first
    always_comb begin
        bits_next  = fresh_reg ? 3'h0 : bits_reg;
        bytes_next = fresh_reg ? 10'h000 : bytes_reg;
        mask_next  = fresh_reg ? '0 : mask_reg;
        op_next    = op_reg;
        addr_next  = addr_reg;
        buf_we     = 1'b0;
        byte_in    = {shift_reg, din};
        shift_next = {shift_reg[5:0], din};
        if (bits_next == 3'h7) begin
            if (bytes_next == 10'h000) begin
                op_next = byte_in;
            end else if (bytes_next < HDR_BYTES_L) begin
                addr_next = {addr_reg[15:0], byte_in};
            end else if ((op_reg == flash_pkg::OP_PP || op_reg == flash_pkg::OP_PW)
                         && !stat.wip) begin
                // data wraps inside the page, up to 256 bytes kept
                buf_we                   = 1'b1;
                mask_next[addr_reg[7:0]] = 1'b1;
                addr_next[7:0]           = addr_reg[7:0] + 8'h01;
            end else if (op_reg == flash_pkg::OP_READ) begin
                addr_next = addr_reg + 24'h000001;
            end
            if (bytes_next != flash_pkg::BYTES_MAX) begin
                bytes_next = bytes_next + 10'h001;
            end
        end
        bits_next = bits_next + 3'h1;
    end

    always_ff @(posedge sck) begin
        bits_reg  <= bits_next;
        bytes_reg <= bytes_next;
        shift_reg <= shift_next;
        op_reg    <= op_next;
        addr_reg  <= addr_next;
        mask_reg  <= mask_next;
    end

    // page buffer write, one byte per completed data byte
    always_ff @(posedge sck) begin
        if (buf_we) begin
            pbuf[addr_reg[7:0]] <= byte_in;
        end
    end

    // output side: drive on falling edge; select high or reset floats it
    assign clr = cs_n | rst_mode;

    always_comb begin
        out_phase = !fresh_reg && stat.armed
                    && ((op_reg == flash_pkg::OP_RDSR && bytes_reg != 10'h000)
                     || (op_reg == flash_pkg::OP_READ && bytes_reg >= HDR_BYTES_L));
        src       = '0;
        src[flash_pkg::ST_WIP] = stat.wip;
        src[flash_pkg::ST_WEL] = stat.wel;
        if (op_reg == flash_pkg::OP_READ) begin
            // array is being changed while busy, so reads return erased value
            src = stat.wip ? flash_pkg::ERASED : rd_data;
        end
        out_next  = out_reg;
        dout_next = dout;
        oe_next   = out_phase;
        if (out_phase && bits_reg == 3'h0) begin
            out_next  = src;
            dout_next = src[7];
        end else if (out_phase) begin
            dout_next = out_reg[3'h7 - bits_reg];
        end
    end

    always_ff @(negedge sck or posedge clr) begin
        if (clr) begin
            out_reg <= 8'h00;
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            out_reg <= out_next;
            dout    <= dout_next;
            dout_oe <= oe_next;
        end
    end

    // frame summary; quasi-static once select is high
    assign cmd.opcode   = op_reg;
    assign cmd.addr     = addr_reg;
    // fresh flag is set again at select high, so it cannot qualify the frame;
    // the counters hold until the next frame clocks, so they can
    assign cmd.bits_ok  = bits_reg == 3'h0 && bytes_reg != 10'h000;
    assign cmd.has_data = bytes_reg >= flash_pkg::DATA_FIRST;
    assign mask         = mask_reg;
    assign rd_addr      = addr_reg[19:0];
    assign buf_data     = pbuf[buf_idx];

endmodule : flash_link

// ---- design/flash_top.sv ----
module flash_top (
    // system clock and reset
    input  wire logic CLK_SYS,
    input  wire logic RST,
    // serial bus
    input  wire logic SCK,
    input  wire logic CS_N,
    input  wire logic DIN,
    output logic      DOUT,
    output logic      DOUT_OE,
    // control pins
    input  wire logic RESET_N,
    input  wire logic W_N,
    // status
    output logic      BUSY,
    output logic      STANDBY
);

    // array of 16 x 256 x 256 bytes
    logic [7:0]              mem  [0:flash_pkg::MEM_BYTES-1];
    logic [7:0]              wbuf [0:255];            // merged page image

    flash_pkg::pins_s        pins_raw, pins_s;        // synchronised pins
    flash_pkg::stat_s        stat_sys, stat_lnk;      // status, both domains
    flash_pkg::cmd_s         cmd;                     // last frame
    logic [255:0]            lnk_mask;                // loaded buffer bytes
    logic [19:0]             rd_addr;
    logic [7:0]              rd_data, buf_data;

    flash_pkg::seq_e         seq_reg, seq_next;       // internal cycle
    logic [15:0]             cnt_reg, cnt_next;       // sweep offset
    logic [15:0]             last_reg, last_next;     // last offset of sweep
    logic [19:0]             base_reg, base_next;     // page or sector base
    logic [7:0]              op_reg, op_next;         // instruction in work
    logic [255:0]            mask_reg, mask_next;     // snapshot of loaded bytes
    logic                    wel_reg, wel_next;       // write enable latch
    logic                    armed_reg, armed_next;   // first select fall seen
    logic                    csp_reg;                 // previous select level
    logic                    rstm_reg;                // reset mode
    logic                    busy_next, stby_next;

    logic                    commit, allowed, prot;
    logic                    mem_we, wbuf_we;
    logic [19:0]             mem_wa;
    logic [7:0]              mem_wd, wbuf_wd, mem_rd;

    // pins cross into the system clock through two flops
    assign pins_raw.cs_n    = CS_N;
    assign pins_raw.reset_n = RESET_N;
    assign pins_raw.wp_n    = W_N;

    flash_sync2 #(
        .W (3)
    ) u_pin_sync (
        .clk (CLK_SYS),
        .d   (pins_raw),
        .q   (pins_s)
    );

    // status crosses into the bus clock; it only runs inside frames
    assign stat_sys.wip   = BUSY;
    assign stat_sys.wel   = wel_reg;
    assign stat_sys.armed = armed_reg;

    flash_sync2 #(
        .W (3)
    ) u_stat_sync (
        .clk (SCK),
        .d   (stat_sys),
        .q   (stat_lnk)
    );

    // both bus clock idle levels work: the front end only uses edges
    flash_link u_link (
        .sck      (SCK),
        .cs_n     (CS_N),
        .din      (DIN),
        .rst_mode (rstm_reg),
        .stat     (stat_lnk),
        .rd_data  (rd_data),
        .rd_addr  (rd_addr),
        .buf_idx  (cnt_reg[7:0]),
        .buf_data (buf_data),
        .cmd      (cmd),
        .mask     (lnk_mask),
        .dout     (DOUT),
        .dout_oe  (DOUT_OE)
    );

    // read port for the front end; blocked by busy on its side
    assign rd_data = mem[rd_addr];

    // sweep address and current array content
    assign mem_wa = base_reg + {4'h0, cnt_reg};
    assign mem_rd = mem[mem_wa];

    // select rising edge ends a frame; its summary is stable by then
    assign commit = pins_s.cs_n && !csp_reg && armed_reg && !rstm_reg;

    // lowest 256 pages locked while write protect is low
    assign prot = !pins_s.wp_n && (cmd.addr[19:0] < flash_pkg::PROT_LIMIT);

    // modify instructions need latch, whole bytes, idle and no lock
    assign allowed = wel_reg && cmd.bits_ok && !prot && seq_reg == flash_pkg::SEQ_IDLE;

    // arming, select edge and reset mode tracking
    always_comb begin
        armed_next = armed_reg;
        if (!pins_s.cs_n && csp_reg) begin
            armed_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            armed_reg <= 1'b0;
            csp_reg   <= 1'b1;
            rstm_reg  <= 1'b0;
        end else begin
            armed_reg <= armed_next;
            csp_reg   <= pins_s.cs_n;
            rstm_reg  <= !pins_s.reset_n;
        end
    end

    // instruction acceptance and internal cycle sequencing
    always_comb begin
        seq_next  = seq_reg;
        cnt_next  = cnt_reg;
        last_next = last_reg;
        base_next = base_reg;
        op_next   = op_reg;
        mask_next = mask_reg;
        wel_next  = wel_reg;
        mem_we    = 1'b0;
        mem_wd    = flash_pkg::ERASED;
        wbuf_we   = 1'b0;
        wbuf_wd   = flash_pkg::ERASED;
        unique case (seq_reg)
            flash_pkg::SEQ_IDLE: begin
                cnt_next = 16'h0000;
                if (commit) begin
                    op_next = cmd.opcode;
                    if (cmd.opcode == flash_pkg::OP_WREN && cmd.bits_ok) begin
                        wel_next = 1'b1;
                    end else if (cmd.opcode == flash_pkg::OP_WRDI && cmd.bits_ok) begin
                        wel_next = 1'b0;
                    end else if ((cmd.opcode == flash_pkg::OP_PW
                                  || cmd.opcode == flash_pkg::OP_PP)
                                 && allowed && cmd.has_data) begin
                        // at least one data byte, whole page is the target
                        seq_next  = flash_pkg::SEQ_FILL;
                        base_next = {cmd.addr[19:8], 8'h00};
                        mask_next = lnk_mask;
                    end else if (cmd.opcode == flash_pkg::OP_PE && allowed) begin
                        seq_next  = flash_pkg::SEQ_ERASE;
                        base_next = {cmd.addr[19:8], 8'h00};
                        last_next = flash_pkg::PAGE_LAST;
                    end else if (cmd.opcode == flash_pkg::OP_SE && allowed) begin
                        seq_next  = flash_pkg::SEQ_ERASE;
                        base_next = {cmd.addr[19:16], 16'h0000};
                        last_next = flash_pkg::SECTOR_LAST;
                    end
                end
            end
            flash_pkg::SEQ_FILL: begin
                // untouched bytes come from the page for a write
                wbuf_we = 1'b1;
                if (mask_reg[cnt_reg[7:0]]) begin
                    wbuf_wd = buf_data;
                end else if (op_reg == flash_pkg::OP_PW) begin
                    wbuf_wd = mem_rd;
                end
                cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg == flash_pkg::PAGE_LAST) begin
                    cnt_next  = 16'h0000;
                    last_next = flash_pkg::PAGE_LAST;
                    // page write erases first, program goes straight on
                    seq_next  = (op_reg == flash_pkg::OP_PW) ? flash_pkg::SEQ_ERASE
                                                             : flash_pkg::SEQ_PROG;
                end
            end
            flash_pkg::SEQ_ERASE: begin
                mem_we   = 1'b1;
                cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg == last_reg) begin
                    cnt_next = 16'h0000;
                    if (op_reg == flash_pkg::OP_PW) begin
                        seq_next = flash_pkg::SEQ_PROG;
                    end else begin
                        seq_next = flash_pkg::SEQ_IDLE;
                        wel_next = 1'b0;
                    end
                end
            end
            flash_pkg::SEQ_PROG: begin
                // programming only clears bits
                mem_we   = 1'b1;
                mem_wd   = mem_rd & wbuf[cnt_reg[7:0]];
                cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg == flash_pkg::PAGE_LAST) begin
                    cnt_next = 16'h0000;
                    seq_next = flash_pkg::SEQ_IDLE;
                    wel_next = 1'b0;
                end
            end
        endcase
        // reset pin drops any cycle half done; data there may be lost
        if (rstm_reg) begin
            seq_next = flash_pkg::SEQ_IDLE;
            cnt_next = 16'h0000;
            wel_next = 1'b0;
            mem_we   = 1'b0;
            wbuf_we  = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            seq_reg  <= flash_pkg::SEQ_IDLE;
            cnt_reg  <= 16'h0000;
            last_reg <= 16'h0000;
            base_reg <= 20'h00000;
            op_reg   <= 8'h00;
            mask_reg <= '0;
            wel_reg  <= 1'b0;
        end else begin
            seq_reg  <= seq_next;
            cnt_reg  <= cnt_next;
            last_reg <= last_next;
            base_reg <= base_next;
            op_reg   <= op_next;
            mask_reg <= mask_next;
            wel_reg  <= wel_next;
        end
    end

    // array and merge buffer writes, one byte per cycle
    always_ff @(posedge CLK_SYS) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        if (wbuf_we) begin
            wbuf[cnt_reg[7:0]] <= wbuf_wd;
        end
    end

    // status outputs: standby once deselected with nothing running
    always_comb begin
        busy_next = seq_next != flash_pkg::SEQ_IDLE;
        stby_next = pins_s.cs_n && !busy_next;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            BUSY    <= 1'b0;
            STANDBY <= 1'b0;
        end else begin
            BUSY    <= busy_next;
            STANDBY <= stby_next;
        end
    end

endmodule : flash_top

// ---- bench/flash_top_chk.sv ----
module flash_top_chk (
    // system side
    input  wire logic CLK_SYS,
    input  wire logic RST,
    // serial bus
    input  wire logic SCK,
    input  wire logic CS_N,
    input  wire logic DIN,
    input  wire logic DOUT,
    input  wire logic DOUT_OE,
    // control and status
    input  wire logic RESET_N,
    input  wire logic W_N,
    input  wire logic BUSY,
    input  wire logic STANDBY
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [16:0] busy_cnt_reg;  // length of the current busy run
    logic [16:0] busy_cnt_next;
    logic        rise_val_reg;  // output level seen at the last rise
    logic        rise_val_next;

    // counter is wide enough for a whole sector sweep
    always_comb begin
        busy_cnt_next = BUSY ? busy_cnt_reg + 17'h00001 : 17'h00000;
        rise_val_next = DOUT;
    end
    always_ff @(posedge CLK_SYS) begin
        busy_cnt_reg <= RST ? 17'h00000 : busy_cnt_next;
    end
    always_ff @(posedge SCK) begin
        rise_val_reg <= rise_val_next;
    end

    // pins held long enough to pass the synchronisers
    sequence s_idle_desel;
        (CS_N && !BUSY) [*4];
    endsequence
    sequence s_reset_held;
        !RESET_N [*6];
    endsequence

    chk_deselect_float: assert property (@(posedge CLK_SYS) disable iff (RST)
        CS_N |-> !DOUT_OE) else $error("output driven while deselected");
    chk_reset_float: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_reset_held |-> !DOUT_OE) else $error("output driven in reset mode");
    chk_active_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
        !CS_N [*4] |-> !STANDBY) else $error("standby while selected");
    chk_standby_entry: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_idle_desel |-> STANDBY) else $error("no standby when idle");
    chk_abort_cycle: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_reset_held |-> !BUSY) else $error("cycle survives reset pin");
    chk_cycle_length: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
        $fell(BUSY) |-> busy_cnt_reg >= 17'h000FF) else $error("cycle ended early");
    chk_start_deselect: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(BUSY) |-> CS_N && $past(CS_N, 2)) else $error("cycle began while selected");
    // level must not move between a rise and the next fall
    chk_shift_on_fall: assert property (@(negedge SCK) disable iff (CS_N)
        DOUT_OE |-> DOUT == rise_val_reg) else $error("output moved off falling edge");
endmodule : flash_top_chk

// ---- bench/spi_master_model.sv ----
module spi_master_model (
    // idle level of the clock
    input  wire logic       cpol,
    // serial pins
    output logic            sck,
    output logic            cs_n,
    output logic            din,
    input  wire logic       dout,
    input  wire logic       dout_oe,
    // last byte of a reading frame
    output logic [7:0]      rx_data,
    output logic            rx_stb
);
    timeunit 1ns;
    timeprecision 100ps;
    logic miso_prev = 1'b0;  // last level taken from the data line

    initial begin
        cs_n = 1'b0;
        sck = 1'b0;
        din = 1'b0;
        rx_data = 8'h00;
        rx_stb = 1'b0;
        // a real rising edge of select presets the front end's frame flag
        #1;
        cs_n = 1'b1;
    end
    // clock stands still at the mode's idle level between frames
    always @(cpol) if (cs_n) sck = cpol;

    // one frame: data set on the fall, both sides sample on the rise
    task automatic frame(input int nbits, input logic [63:0] tx, input bit rd);
        logic [7:0] sh;
        logic       m;
        sh = 8'h00;
        cs_n = 1'b0;
        #20;
        for (int i = 0; i < nbits; i++) begin
            sck = 1'b0;
            din = tx[63-i];
            #7.5;
            sck = 1'b1;
            // a floating line shows the inverse, never a stale level
            m = dout_oe ? dout : ~miso_prev;
            miso_prev = m;
            sh = {sh[6:0], m};
            #7.5;
        end
        sck = cpol;
        #20;
        cs_n = 1'b1;
        din = ~din;
        #500;  // deselect gap above four system cycles
        if (rd) begin
            rx_data = sh;
            rx_stb = 1'b1;
            #1;
            rx_stb = 1'b0;
        end
    endtask : frame
endmodule : spi_master_model

// ---- bench/test_flash_top.sv ----
module test_flash_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        reset_n = 1'b1;
    logic        w_n = 1'b1;
    logic        cpol = 1'b0;
    wire logic   sck, cs_n, din, dout, dout_oe, busy, standby, rx_stb;
    wire logic [7:0] rx_data;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [7:0]  exp_q[$];  // expected bytes of reading frames
    logic [31:0] seed = 32'h000022A9;
    logic [7:0]  d0, d1, d2;

    always #50 clk_sys = ~clk_sys;

    flash_top dut (.CLK_SYS(clk_sys), .RST(rst), .SCK(sck), .CS_N(cs_n), .DIN(din),
        .DOUT(dout), .DOUT_OE(dout_oe), .RESET_N(reset_n), .W_N(w_n), .BUSY(busy),
        .STANDBY(standby));
    spi_master_model m (.cpol(cpol), .sck(sck), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .rx_data(rx_data), .rx_stb(rx_stb));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xorshift

    task automatic compare_byte(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask : compare_byte

    task automatic compare_flag(input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask : compare_flag

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // each reading frame is matched with the oldest note
    always @(posedge rx_stb) begin
        if (exp_q.size() == 0) begin
            compare_byte(8'h00, rx_data ^ 8'hFF);
        end else begin
            compare_byte(exp_q.pop_front(), rx_data);
        end
    end

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict;
        end
    end

    task automatic wren;
        m.frame(8, {flash_pkg::OP_WREN, 56'h0}, 1'b0);
    endtask : wren

    task automatic read_chk(input logic [19:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        m.frame(40, {flash_pkg::OP_READ, 4'h0, addr, 32'h0}, 1'b1);
    endtask : read_chk

    task automatic status_chk(input logic [7:0] exp);
        exp_q.push_back(exp);
        m.frame(16, {flash_pkg::OP_RDSR, 56'h0}, 1'b1);
    endtask : status_chk

    // bounded wait for the internal cycle to finish
    task automatic wait_done;
        int k;
        k = 0;
        repeat (5) @(negedge clk_sys);
        while (busy !== 1'b0 && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        compare_flag(1'b0, busy);
        compare_flag(1'b1, standby);
    endtask : wait_done

    task automatic chk_refused;
        repeat (8) @(negedge clk_sys);
        compare_flag(1'b0, busy);
    endtask : chk_refused

    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        d0 = seed[7:0];
        seed = xorshift(seed);
        d1 = seed[7:0];
        seed = xorshift(seed);
        d2 = seed[7:0];
        // erase a page, then program two bytes that wrap at its end
        wren;
        m.frame(32, {flash_pkg::OP_PE, 24'h010100, 32'h0}, 1'b0);
        wait_done;
        read_chk(20'h10100, 8'hFF);
        wren;
        m.frame(48, {flash_pkg::OP_PP, 24'h0101FF, d0, d1, 16'h0}, 1'b0);
        wait_done;
        read_chk(20'h101FF, d0);
        read_chk(20'h10100, d1);
        status_chk(8'h00);
        $display("page program test done");
        // page write with the clock idling high keeps untouched bytes
        @(negedge clk_sys) cpol = 1'b1;
        wren;
        m.frame(40, {flash_pkg::OP_PW, 24'h010105, d2, 24'h0}, 1'b0);
        wait_done;
        read_chk(20'h10105, d2);
        read_chk(20'h10100, d1);
        read_chk(20'h10101, 8'hFF);
        @(negedge clk_sys) cpol = 1'b0;
        $display("page write test done");
        // bottom sector locked, ragged frame ignored
        @(negedge clk_sys) w_n = 1'b0;
        wren;
        m.frame(32, {flash_pkg::OP_PE, 24'h000100, 32'h0}, 1'b0);
        chk_refused;
        @(negedge clk_sys) w_n = 1'b1;
        wren;
        m.frame(33, {flash_pkg::OP_PE, 24'h010100, 32'h0}, 1'b0);
        chk_refused;
        $display("refusal test done");
        // sector erase cut short by the reset pin
        wren;
        m.frame(32, {flash_pkg::OP_SE, 24'h010000, 32'h0}, 1'b0);
        repeat (50) @(negedge clk_sys);
        compare_flag(1'b1, busy);
        reset_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        compare_flag(1'b0, busy);
        m.frame(16, {flash_pkg::OP_RDSR, 56'h0}, 1'b0);
        @(negedge clk_sys) reset_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        status_chk(8'h00);
        // unlocked page 1 of the bottom sector erases normally
        wren;
        m.frame(32, {flash_pkg::OP_PE, 24'h000100, 32'h0}, 1'b0);
        wait_done;
        read_chk(20'h00100, 8'hFF);
        $display("reset and unlock test done");
        repeat (10) @(negedge clk_sys);
        print_verdict;
    end
endmodule : test_flash_top

bind flash_top flash_top_chk chk (.CLK_SYS(CLK_SYS), .RST(RST), .SCK(SCK), .CS_N(CS_N),
    .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .RESET_N(RESET_N), .W_N(W_N),
    .BUSY(BUSY), .STANDBY(STANDBY));
